/* File: design/eeprom_link_defs.svh */
// Purpose: shared constants for the two-wire eeprom addressing front end
// Assumes: 20 MHz system clock on both ends
// Notes: timing counts derive from printed times and the clock period
`ifndef EEPROM_LINK_DEFS_SVH
`define EEPROM_LINK_DEFS_SVH
`define CLK_PERIOD_NS 50
// memory-class type code: the value is arbitrary, the slave and the bench share it
`define TYPE_CODE 4'h5
`define TYPE_MSB 7
`define TYPE_LSB 4
`define TOP_SEL_BIT 3
`define BLOCK_MSB 2
`define BLOCK_LSB 1
`define RW_BIT 0
`define FILTER_STD_NS 100
`define FILTER_FAST_NS 50
`define FILTER_STD_CYC ((`FILTER_STD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FILTER_FAST_CYC ((`FILTER_FAST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PROG_HI_MS 10
`define PROG_LO_MS 15
`define PROG_HI_CYC (`PROG_HI_MS * 1000000 / `CLK_PERIOD_NS)
`define PROG_LO_CYC (`PROG_LO_MS * 1000000 / `CLK_PERIOD_NS)
`define SCL_HALF_CYC 4
`endif

/* File: design/eeprom_link_pkg.sv */
// Purpose: types shared by both ends of the link
// Assumes: nothing beyond the defs header
// Notes: holds types only
package eeprom_link_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_DEVADR = 3'b001,
    S_DEVACK = 3'b010,
    S_ARRADR = 3'b011,
    S_ARRACK = 3'b100,
    S_DATA = 3'b101,
    S_DATACK = 3'b110,
    S_IGNORE = 3'b111
  } slave_state_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BIT = 3'b010,
    M_ACK = 3'b011,
    M_STOP = 3'b100,
    M_DONE = 3'b101
  } master_state_t;
endpackage

/* File: design/eeprom_link_if.sv */
// Purpose: open-drain two-wire link between master and eeprom slave
// Assumes: pull-ups on both lines
// Notes: wire levels resolved from enables
`timescale 1ns/1ps
interface eeprom_link_if;
  logic scl_oe;
  logic sda_m_oe;
  logic sda_s_oe;
  logic scl;
  logic sda;
  // wired-and with pull-up: any enable pulls the line low
  assign scl = ~scl_oe;
  assign sda = ~(sda_m_oe | sda_s_oe);
  modport master (output scl_oe, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_oe, input scl, input sda);
endinterface

/* File: design/eeprom_slave.sv */
// Purpose: slave end: start/stop detect, address decode, ack, program cycle
// Assumes: mclk 20 MHz, link lines asynchronous to mclk
// Notes: memory array itself is outside; data bytes are handed out
`timescale 1ns/1ps
`include "eeprom_link_defs.svh"
// Behaviour
// - after write stop, run timed program cycle
// - during program cycle, ignore bus, release data
// - master opens with start, closes with stop
// - slave address acked, then array address follows
// - address byte: type, select, read/write
// - selected only if type and select match
// - top select bit compares pin, others choose block
// - four page blocks of 256 bytes
// - last bit one reads, zero writes
// - receiver holds data low during ninth clock
// - receiver acks every byte it accepts
// - array address picks byte within block
// - suppress short glitches on clock and data (standard mode only; the 1-cycle fast-mode filter takes any sampled level)
// - start is data falling, clock high
// - stop is data rising, clock high
module eeprom_slave
  import eeprom_link_pkg::*;
#(
  parameter int unsigned PROG_HI_CYC = `PROG_HI_CYC,
  parameter int unsigned PROG_LO_CYC = `PROG_LO_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // straps
  input wire logic top_chip_select_pin,
  input wire logic low_supply,
  input wire logic fast_mode,
  // link
  eeprom_link_if.slave link,
  // user side
  output logic [1:0] block_sel,
  output logic [7:0] array_addr,
  output logic [7:0] wr_data,
  output logic wr_strobe,
  output logic read_sel,
  output logic prog_busy
);
  logic [1:0] scl_sync_reg, sda_sync_reg;
  logic scl_f_reg, sda_f_reg, scl_prev_reg, sda_prev_reg;
  logic [1:0] scl_cnt_reg, sda_cnt_reg;
  slave_state_t state_reg;
  logic [7:0] shift_reg;
  logic [3:0] bit_reg;
  logic ack_oe_reg;
  logic write_seen_reg;
  logic [31:0] prog_cnt_reg;
  logic [1:0] filt_len;
  wire scl_rise, scl_fall, start_det, stop_det, sel_match, bit8;
  wire [7:0] shift_next;
  wire [31:0] prog_len;

  // filter length by speed grade; rounded up so a minimum glitch is held off in standard mode; fast mode's 1 cycle lets it through
  assign filt_len = fast_mode ? 2'(`FILTER_FAST_CYC) : 2'(`FILTER_STD_CYC);
  assign prog_len = low_supply ? PROG_LO_CYC : PROG_HI_CYC;

  // two-flop synchronisers; only stage 2 feeds logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], link.scl};
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
    end
  end

  // glitch filter: a new level must persist filt_len cycles before it is taken
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_f_reg <= 1'b1;
      sda_f_reg <= 1'b1;
      scl_cnt_reg <= 2'h0;
      sda_cnt_reg <= 2'h0;
    end else begin
      scl_cnt_reg <= (scl_sync_reg[1] == scl_f_reg) ? 2'h0 : scl_cnt_reg + 2'h1;
      if (scl_sync_reg[1] != scl_f_reg && scl_cnt_reg + 2'h1 >= filt_len)
        scl_f_reg <= scl_sync_reg[1];
      sda_cnt_reg <= (sda_sync_reg[1] == sda_f_reg) ? 2'h0 : sda_cnt_reg + 2'h1;
      if (sda_sync_reg[1] != sda_f_reg && sda_cnt_reg + 2'h1 >= filt_len)
        sda_f_reg <= sda_sync_reg[1];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_f_reg;
      sda_prev_reg <= sda_f_reg;
    end
  end

  // line events on the filtered levels
  assign scl_rise = scl_f_reg & ~scl_prev_reg;
  assign scl_fall = ~scl_f_reg & scl_prev_reg;
  assign start_det = scl_f_reg & scl_prev_reg & sda_prev_reg & ~sda_f_reg;
  assign stop_det = scl_f_reg & scl_prev_reg & ~sda_prev_reg & sda_f_reg;
  assign shift_next = {shift_reg[6:0], sda_f_reg};
  assign bit8 = (bit_reg == 4'h7) & scl_rise;
  // type field plus the one physical select pin; lower bits pick the block
  assign sel_match = (shift_next[`TYPE_MSB:`TYPE_LSB] == `TYPE_CODE)
                   & (shift_next[`TOP_SEL_BIT] == top_chip_select_pin);

  // program cycle timer; bus is ignored while it runs
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prog_cnt_reg <= 32'h0;
    end else if (prog_cnt_reg != 32'h0) begin
      prog_cnt_reg <= prog_cnt_reg - 32'h1;
    end else if (stop_det && write_seen_reg) begin
      prog_cnt_reg <= prog_len;
    end
  end
  assign prog_busy = (prog_cnt_reg != 32'h0);

  // protocol state machine
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      ack_oe_reg <= 1'b0;
      write_seen_reg <= 1'b0;
      block_sel <= 2'h0;
      array_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_strobe <= 1'b0;
      read_sel <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      if (prog_busy) begin
        state_reg <= S_IDLE;
        ack_oe_reg <= 1'b0;
        write_seen_reg <= 1'b0;
      end else if (stop_det) begin
        state_reg <= S_IDLE;
        ack_oe_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= S_DEVADR;
        bit_reg <= 4'h0;
        ack_oe_reg <= 1'b0;
        write_seen_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          S_IDLE, S_IGNORE: begin
            ack_oe_reg <= 1'b0;
          end
          S_DEVADR, S_ARRADR, S_DATA: begin
            if (scl_rise) begin
              shift_reg <= shift_next;
              bit_reg <= bit_reg + 4'h1;
            end
            if (bit8) begin
              bit_reg <= 4'h0;
              if (state_reg == S_DEVADR) begin
                if (sel_match) begin
                  state_reg <= S_DEVACK;
                  block_sel <= shift_next[`BLOCK_MSB:`BLOCK_LSB];
                  read_sel <= shift_next[`RW_BIT];
                end else begin
                  state_reg <= S_IGNORE;
                end
              end else if (state_reg == S_ARRADR) begin
                state_reg <= S_ARRACK;
                array_addr <= shift_next;
              end else begin
                state_reg <= S_DATACK;
                wr_data <= shift_next;
                wr_strobe <= 1'b1;
                write_seen_reg <= 1'b1;
              end
            end
          end
          S_DEVACK, S_ARRACK, S_DATACK: begin
            // drive low from the fall after bit 8 until the fall after clock 9
            if (scl_fall) begin
              ack_oe_reg <= ~ack_oe_reg;
              if (ack_oe_reg) begin
                if (state_reg == S_DEVACK)
                  state_reg <= read_sel ? S_IGNORE : S_ARRADR;
                else
                  state_reg <= S_DATA;
              end
            end
          end
        endcase
      end
    end
  end

  // open drain: only ever pull low, released during program cycle
  assign link.sda_s_oe = ack_oe_reg & ~prog_busy;
endmodule

/* File: design/eeprom_master.sv */
// Purpose: master end: start, address bytes, one optional data byte, stop
// Assumes: mclk 20 MHz; slave ack sampled through two flops
// Notes: makes scl by dividing mclk; write transfers only
`timescale 1ns/1ps
`include "eeprom_link_defs.svh"
module eeprom_master
  import eeprom_link_pkg::*;
#(
  parameter int unsigned HALF_CYC = `SCL_HALF_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link
  eeprom_link_if.master link,
  // user request
  input wire logic req,
  input wire logic [7:0] dev_byte,
  input wire logic [7:0] addr_byte,
  input wire logic [7:0] data_byte,
  input wire logic with_data,
  output logic busy,
  output logic done,
  output logic nack
);
  master_state_t state_reg;
  logic [1:0] sda_sync_reg;
  logic [7:0] cnt_reg;
  logic phase_reg;
  logic [7:0] sh_reg;
  logic [2:0] bit_reg;
  logic [1:0] byte_reg;
  logic scl_low_reg, sda_low_reg;
  wire tick, last_byte;

  // divider: tick every half scl period
  assign tick = (cnt_reg == 8'(HALF_CYC - 1));
  assign last_byte = with_data ? (byte_reg == 2'h2) : (byte_reg == 2'h1);
  assign busy = (state_reg != M_IDLE);
  assign link.scl_oe = scl_low_reg;
  assign link.sda_m_oe = sda_low_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sda_sync_reg <= 2'h3;
      cnt_reg <= 8'h00;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], link.sda};
      cnt_reg <= (tick || state_reg == M_IDLE) ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  // phase 0 = scl low half, phase 1 = scl high half
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= M_IDLE;
      phase_reg <= 1'b0;
      sh_reg <= 8'h00;
      bit_reg <= 3'h0;
      byte_reg <= 2'h0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      done <= 1'b0;
      nack <= 1'b0;
    end else begin
      done <= 1'b0;
      unique case (state_reg)
        M_IDLE: begin
          if (req) begin
            state_reg <= M_START;
            sh_reg <= dev_byte;
            byte_reg <= 2'h0;
            nack <= 1'b0;
          end
        end
        M_START: if (tick) begin
          phase_reg <= ~phase_reg;
          if (!phase_reg) begin
            sda_low_reg <= 1'b1;
          end else begin
            // start held for a half period, then the first bit goes out on the fall
            scl_low_reg <= 1'b1;
            sda_low_reg <= ~sh_reg[7];
            bit_reg <= 3'h0;
            state_reg <= M_BIT;
          end
        end
        M_BIT: if (tick) begin
          phase_reg <= ~phase_reg;
          if (!phase_reg) begin
            scl_low_reg <= 1'b0;
          end else begin
            // the fall ends the bit; data only changes while the clock is low
            scl_low_reg <= 1'b1;
            sh_reg <= {sh_reg[6:0], 1'b0};
            bit_reg <= bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              state_reg <= M_ACK;
              sda_low_reg <= 1'b0;
            end else begin
              sda_low_reg <= ~sh_reg[6];
            end
          end
        end
        M_ACK: if (tick) begin
          phase_reg <= ~phase_reg;
          scl_low_reg <= phase_reg;
          if (phase_reg) begin
            if (sda_sync_reg[1] || last_byte) begin
              nack <= sda_sync_reg[1];
              state_reg <= M_STOP;
              sda_low_reg <= 1'b1;
            end else begin
              byte_reg <= byte_reg + 2'h1;
              sh_reg <= (byte_reg == 2'h0) ? addr_byte : data_byte;
              sda_low_reg <= ~((byte_reg == 2'h0) ? addr_byte[7] : data_byte[7]);
              bit_reg <= 3'h0;
              state_reg <= M_BIT;
            end
          end
        end
        M_STOP: if (tick) begin
          phase_reg <= ~phase_reg;
          // release the clock first, then the data line while the clock is high
          if (!phase_reg) begin
            scl_low_reg <= 1'b0;
          end else begin
            sda_low_reg <= 1'b0;
            state_reg <= M_DONE;
          end
        end
        M_DONE: begin
          done <= 1'b1;
          phase_reg <= 1'b0;
          state_reg <= M_IDLE;
        end
        default: state_reg <= M_IDLE;
      endcase
    end
  end
endmodule

/* File: bench/eeprom_link_sva.sv */
// Purpose: checks on the link wires and program timing of the eeprom pair
// Assumes: one mclk domain, rstn async low
// Notes: watches the shared interface plus two slave status outputs
`timescale 1ns/1ps
module eeprom_link_sva #(
  parameter int unsigned PROG_HI_CYC = 600,
  parameter int unsigned PROG_LO_CYC = 900
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // link
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  // slave status
  input wire logic prog_busy,
  input wire logic wr_strobe
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  int unsigned run_reg;
  // length of the running program cycle, so long waits need no repetition
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      run_reg <= 0;
    end else begin
      run_reg <= prog_busy ? run_reg + 1 : 0;
    end
  end
  a_ack_moves_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data enable moved while clock high");
  a_ack_held_high: assert property ((sda_s_oe && scl) |=> (sda_s_oe || !scl))
    else $error("acknowledge dropped during clock high");
  a_ack_one_clock: assert property ($rose(sda_s_oe) |-> sda_s_oe [*8] ##[1:32] !sda_s_oe)
    else $error("acknowledge width outside one clock");
  a_busy_quiet: assert property (prog_busy |-> !sda_s_oe)
    else $error("slave drives data during program cycle");
  a_busy_after_stop: assert property ($rose(prog_busy) |-> scl && sda)
    else $error("program cycle began with bus not at rest");
  a_busy_bound: assert property (prog_busy |-> run_reg < PROG_LO_CYC)
    else $error("program cycle too long");
  a_busy_length: assert property ($fell(prog_busy) |-> (run_reg == PROG_HI_CYC || run_reg == PROG_LO_CYC))
    else $error("program cycle length wrong");
  a_strobe_single: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  a_strobe_not_busy: assert property (wr_strobe |-> !prog_busy)
    else $error("byte taken during program cycle");
  // main scenarios reached
  cover property ($rose(sda_s_oe));
  cover property ($fell(prog_busy));
  cover property (wr_strobe);
endmodule

/* File: bench/i2c_eeprom_slave_addressing_test.sv */
// Purpose: master and slave ends joined, checked against a small model
// Assumes: mclk 20 MHz, link clock from the master divider (8 cycles a half)
// Notes: program times shortened through parameters to keep the run short
`timescale 1ns/1ps
`include "eeprom_link_defs.svh"
module i2c_eeprom_slave_addressing_test;
  import eeprom_link_pkg::*;
  localparam int unsigned HI = 600;
  localparam int unsigned LO = 900;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic top_chip_select_pin = 1'b0;
  logic low_supply = 1'b0;
  logic fast_mode = 1'b0;
  logic req = 1'b0;
  logic with_data = 1'b0;
  logic [7:0] dev_byte = 8'h00;
  logic [7:0] addr_byte = 8'h00;
  logic [7:0] data_byte = 8'h00;
  logic [1:0] block_sel;
  logic [7:0] array_addr;
  logic [7:0] wr_data;
  logic wr_strobe, read_sel, prog_busy, busy, done, nack;
  int fails = 0;
  int comparisons = 0;
  int strobes = 0;
  int run = 0;
  int busy_len = 0;
  eeprom_link_if u_eeprom_link_if ();
  eeprom_slave #(.PROG_HI_CYC(HI), .PROG_LO_CYC(LO)) u_eeprom_slave (.mclk(mclk), .rstn(rstn),
    .top_chip_select_pin(top_chip_select_pin), .low_supply(low_supply), .fast_mode(fast_mode),
    .link(u_eeprom_link_if.slave), .block_sel(block_sel), .array_addr(array_addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .read_sel(read_sel), .prog_busy(prog_busy));
  eeprom_master #(.HALF_CYC(8)) u_eeprom_master (.mclk(mclk), .rstn(rstn), .link(u_eeprom_link_if.master),
    .req(req), .dev_byte(dev_byte), .addr_byte(addr_byte), .data_byte(data_byte), .with_data(with_data),
    .busy(busy), .done(done), .nack(nack));
  eeprom_link_sva #(.PROG_HI_CYC(HI), .PROG_LO_CYC(LO)) u_eeprom_link_sva (.mclk(mclk), .rstn(rstn),
    .scl(u_eeprom_link_if.scl), .sda(u_eeprom_link_if.sda), .sda_s_oe(u_eeprom_link_if.sda_s_oe),
    .prog_busy(prog_busy), .wr_strobe(wr_strobe));
  always #25 mclk = ~mclk;
  // count strobes and latch each program cycle length when it ends
  always @(posedge mclk) begin
    strobes <= strobes + int'(wr_strobe);
    run <= prog_busy ? run + 1 : 0;
    if (!prog_busy && run > 0) begin
      busy_len <= run;
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // straps change only between transfers; one edge lets them land
  task automatic straps(input logic pin, input logic ls, input logic fm);
    top_chip_select_pin <= pin;
    low_supply <= ls;
    fast_mode <= fm;
    @(posedge mclk);
  endtask
  // one transfer; the model predicts the last ack and the captured fields
  task automatic xfer(input logic [7:0] dev, input logic [7:0] adr, input logic [7:0] dat, input logic wd,
                      input bit busy_now, output bit prog);
    int n;
    int s0;
    bit sel;
    sel = dev[7:4] == `TYPE_CODE && dev[3] == top_chip_select_pin && !busy_now;
    prog = sel && !dev[0] && wd;
    s0 = strobes;
    dev_byte <= dev;
    addr_byte <= adr;
    data_byte <= dat;
    with_data <= wd;
    req <= 1'b1;
    @(posedge mclk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (done !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      fails++;
    end
    check("nack", 16'(!(sel && !dev[0])), 16'(nack));
    check("strobes", 16'(sel && !dev[0] && wd), 16'(strobes - s0));
    check("busy", 16'h0000, 16'(busy));
    if (sel) begin
      check("block_sel", 16'(dev[2:1]), 16'(block_sel));
      check("read_sel", 16'(dev[0]), 16'(read_sel));
    end
    if (sel && !dev[0]) begin
      check("array_addr", 16'(adr), 16'(array_addr));
    end
    if (prog) begin
      check("wr_data", 16'(dat), 16'(wr_data));
    end
  endtask
  // wait out any program cycle and compare its length with the strap
  task automatic prog_check(input bit expect_run);
    int n;
    busy_len = 0;
    repeat (20) @(posedge mclk);
    n = 0;
    while (prog_busy !== 1'b0 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    check("prog_len", expect_run ? (low_supply ? 16'(LO) : 16'(HI)) : 16'h0000, 16'(busy_len));
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    fails++;
    wrap_up();
  end
  initial begin
    int i;
    bit p;
    logic [7:0] d;
    void'($urandom(35));
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    // every page block, both supply ranges, both filter speeds
    for (i = 0; i < 4; i++) begin
      straps(i[0], i[1], ~i[0]);
      xfer({`TYPE_CODE, i[0], 2'(i), 1'b0}, 8'($urandom), 8'($urandom), 1'b1, 1'b0, p);
      prog_check(p);
    end
    // address sent again during the program cycle is not answered
    xfer({`TYPE_CODE, 1'b1, 2'h2, 1'b0}, 8'hFF, 8'h00, 1'b1, 1'b0, p);
    xfer({`TYPE_CODE, 1'b1, 2'h2, 1'b0}, 8'h3C, 8'h00, 1'b0, 1'b1, p);
    prog_check(1'b1);
    // read access and a write without data start no program cycle
    xfer({`TYPE_CODE, 1'b1, 2'h1, 1'b1}, 8'h80, 8'h00, 1'b0, 1'b0, p);
    prog_check(p);
    xfer({`TYPE_CODE, 1'b1, 2'h3, 1'b0}, 8'h00, 8'h00, 1'b0, 1'b0, p);
    prog_check(p);
    // random addresses, half of them with the right type field
    for (i = 0; i < 16; i++) begin
      straps(1'($urandom), 1'($urandom), 1'($urandom));
      d = 8'($urandom);
      if ($urandom % 2 == 0) begin
        d[7:4] = `TYPE_CODE;
      end
      xfer(d, 8'($urandom), 8'($urandom), 1'($urandom), 1'b0, p);
      prog_check(p);
    end
    wrap_up();
  end
endmodule
